// ===== core/ebt_timer.sv
// 8-bit compare timer: counter, two compares, waveform output, flags.
// Assumes synchronous pins and a one-cycle register port.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module ebt_timer (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire ebt_pkg::ebt_bus_req_t bus_req,
  output logic [7:0]                rd_data,
  input  wire ebt_pkg::ebt_pins_t    pins,
  input  wire logic                 standby_hold,
  output logic                      waveform_out_pin,
  output logic                      timer_irq,
  output logic [15:0]               irq_vector
);
  import ebt_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]         counter_value_q;
  logic [7:0]         counter_value_d;
  logic [7:0]         compare_value_a_q;
  logic [7:0]         compare_value_b_q;
  logic [7:0]         control_register_zero_q;
  logic [3:0]         output_select_field_q;
  logic [2:0]         flags_q;
  logic [2:0]         flags_d;
  logic [2:0]         seen_q;
  logic [2:0]         seen_d;
  logic [1:0]         trig_edge_q;
  logic               trigger_enable_bit_q;
  logic               internal_clock_extra_bit_q;
  logic [PRESC_W-1:0] presc_q;
  logic               lvl_q;
  ebt_run_t           run_q;
  ebt_run_t           run_d;
  logic               out_q;
  logic               out_d;
  logic               irq_q;
  logic [7:0]         rdata_q;
  logic [7:0]         rd_mux;
  logic [15:0]        vec_q;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_cnt  = bus_req.wr && (bus_req.addr == ADDR_COUNT);
  wire wr_cmpa = bus_req.wr && (bus_req.addr == ADDR_CMP_A);
  wire wr_cmpb = bus_req.wr && (bus_req.addr == ADDR_CMP_B);
  wire wr_ctl0 = bus_req.wr && (bus_req.addr == ADDR_CTL0);
  wire wr_csr  = bus_req.wr && (bus_req.addr == ADDR_CSR);
  wire wr_ctl1 = bus_req.wr && (bus_req.addr == ADDR_CTL1);
  wire rd_csr  = bus_req.rd && (bus_req.addr == ADDR_CSR);

  wire [1:0] clear_sel = {control_register_zero_q[CTL0_CLR_HI],
                          control_register_zero_q[CTL0_CLR_LO]};
  wire [2:0] clock_source_field = control_register_zero_q[CTL0_CKS_HI:0];
  wire [2:0] irq_en = {control_register_zero_q[CTL0_IE_A],
                       control_register_zero_q[CTL0_IE_B],
                       control_register_zero_q[CTL0_IE_OVF]};

  // ---------------------------------------------------------------
  // Pin edges
  // ---------------------------------------------------------------
  logic [PIN_COUNT-1:0] pin_vec;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;

  assign pin_vec[PIN_TRG] = pins.trigger_input_pin;
  assign pin_vec[PIN_CLR] = pins.counter_reset_input_pin;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_edge
      ebt_edge u_edge (
        .ref_clk (ref_clk),
        .rst     (rst),
        .hold    (standby_hold),
        .pin     (pin_vec[gi]),
        .rise    (pin_rise[gi]),
        .fall    (pin_fall[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Count source selection
  // ---------------------------------------------------------------
  function automatic logic pick_level(input logic [2:0]         cks,
                                      input logic               icks,
                                      input logic [PRESC_W-1:0] pre,
                                      input logic               ext);
    logic lv;
    lv = 1'b0;
    case (cks)
      3'h1:         lv = icks ? pre[2] : pre[1];
      3'h2:         lv = icks ? pre[4] : pre[3];
      3'h3:         lv = icks ? pre[6] : pre[5];
      CKS_EXT_RISE: lv = ~ext;
      CKS_EXT_FALL: lv = ext;
      CKS_EXT_BOTH: lv = ext;
      default:      lv = 1'b0;
    endcase
    return lv;
  endfunction : pick_level

  // Single shared level: a switch of source is seen as an edge
  wire src_lvl = pick_level(clock_source_field, internal_clock_extra_bit_q,
                            presc_q, pins.ext_clock_pin);
  wire both_edges = (clock_source_field == CKS_EXT_BOTH);
  wire cnt_tick = both_edges ? (lvl_q ^ src_lvl)
                             : (lvl_q & ~src_lvl);

  // ---------------------------------------------------------------
  // Trigger, match and clear
  // ---------------------------------------------------------------
  wire trig_ev = ((trig_edge_q == EDGE_RISE) && pin_rise[PIN_TRG]) ||
                 ((trig_edge_q == EDGE_FALL) && pin_fall[PIN_TRG]) ||
                 ((trig_edge_q == EDGE_BOTH) &&
                  (pin_rise[PIN_TRG] || pin_fall[PIN_TRG]));
  wire counting = !trigger_enable_bit_q || (run_q == ST_COUNT);
  wire inc = cnt_tick && counting;

  // Match fires as the counter leaves the equal value
  wire match_a = inc && (counter_value_q == compare_value_a_q)
                 && !wr_cmpa;
  wire match_b = inc && (counter_value_q == compare_value_b_q)
                 && !wr_cmpb;

  // Pin pulses shorter than 1 clock may be missed
  wire clr_pin = (clear_sel == CLR_PIN) && pin_rise[PIN_CLR];
  wire clr = ((clear_sel == CLR_A) && match_a) ||
             ((clear_sel == CLR_B) && match_b) ||
             clr_pin;
  wire ovf = inc && (counter_value_q == COUNT_TOP) && !clr && !wr_cnt;

  always_comb begin
    if (clr) begin
      counter_value_d = RST_COUNT;
    end else if (wr_cnt) begin
      counter_value_d = bus_req.wdata;
    end else if (inc) begin
      counter_value_d = counter_value_q + 8'h01;
    end else begin
      counter_value_d = counter_value_q;
    end
  end

  always_comb begin
    run_d = run_q;
    case (run_q)
      ST_HALT: begin
        if (trig_ev) begin
          run_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (clr && trigger_enable_bit_q) begin
          run_d = ST_HALT;
        end
      end
      default: run_d = ST_HALT;
    endcase
    if (wr_ctl1 && bus_req.wdata[CTL1_TRG_EN]) begin
      run_d = ST_HALT;
    end
  end

  // ---------------------------------------------------------------
  // Waveform output
  // ---------------------------------------------------------------
  wire [1:0] act_a = match_a ? output_select_field_q[1:0] : ACT_HOLD;
  wire [1:0] act_b = match_b ? output_select_field_q[3:2] : ACT_HOLD;
  // Encoding order equals priority order
  wire [1:0] act = (act_a > act_b) ? act_a : act_b;

  always_comb begin
    case (act)
      ACT_LOW:  out_d = 1'b0;
      ACT_HIGH: out_d = 1'b1;
      ACT_TOG:  out_d = ~out_q;
      default:  out_d = out_q;
    endcase
  end

  // ---------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------
  wire [2:0] flag_set = {match_a, match_b, ovf};
  wire [2:0] wr_flags = {bus_req.wdata[CSR_FLAG_A], bus_req.wdata[CSR_FLAG_B],
                         bus_req.wdata[CSR_FLAG_OVF]};
  // Clear needs a prior read of 1; a new event wins over clear
  wire [2:0] flag_clr = wr_csr ? (seen_q & ~wr_flags) : 3'b000;

  assign flags_d = flag_set | (flags_q & ~flag_clr);
  assign seen_d  = rd_csr ? (seen_q | flags_q)
                          : (wr_csr ? 3'b000 : seen_q);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    case (bus_req.addr)
      ADDR_COUNT: rd_mux = counter_value_q;
      ADDR_CMP_A: rd_mux = compare_value_a_q;
      ADDR_CMP_B: rd_mux = compare_value_b_q;
      ADDR_CTL0:  rd_mux = control_register_zero_q;
      ADDR_CSR:   rd_mux = CSR_ONES | {flags_q, 1'b0, output_select_field_q};
      ADDR_CTL1:  rd_mux = CTL1_ONES | {3'b000, trig_edge_q,
                                        trigger_enable_bit_q, 1'b0,
                                        internal_clock_extra_bit_q};
      default:    rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      counter_value_q <= RST_COUNT;
      run_q           <= ST_HALT;
      lvl_q           <= 1'b0;
      presc_q         <= '0;
    end else if (standby_hold) begin
      counter_value_q <= RST_COUNT;
      run_q           <= ST_HALT;
      lvl_q           <= 1'b0;
      presc_q         <= '0;
    end else begin
      counter_value_q <= counter_value_d;
      run_q           <= run_d;
      lvl_q           <= src_lvl;
      presc_q         <= presc_q + 7'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_value_a_q       <= RST_CMP;
      compare_value_b_q       <= RST_CMP;
      control_register_zero_q <= RST_CTL0;
    end else if (standby_hold) begin
      compare_value_a_q       <= RST_CMP;
      compare_value_b_q       <= RST_CMP;
      control_register_zero_q <= RST_CTL0;
    end else begin
      if (wr_cmpa) begin
        compare_value_a_q <= bus_req.wdata;
      end
      if (wr_cmpb) begin
        compare_value_b_q <= bus_req.wdata;
      end
      if (wr_ctl0) begin
        control_register_zero_q <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      output_select_field_q      <= RST_OS;
      flags_q                    <= 3'b000;
      seen_q                     <= 3'b000;
      trig_edge_q                <= EDGE_OFF;
      trigger_enable_bit_q       <= 1'b0;
      internal_clock_extra_bit_q <= 1'b0;
    end else if (standby_hold) begin
      output_select_field_q      <= RST_OS;
      flags_q                    <= 3'b000;
      seen_q                     <= 3'b000;
      trig_edge_q                <= EDGE_OFF;
      trigger_enable_bit_q       <= 1'b0;
      internal_clock_extra_bit_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      seen_q  <= seen_d;
      if (wr_csr) begin
        output_select_field_q <= bus_req.wdata[3:0];
      end
      if (wr_ctl1) begin
        trig_edge_q                <= {bus_req.wdata[CTL1_EDGE_HI],
                                       bus_req.wdata[CTL1_EDGE_LO]};
        trigger_enable_bit_q       <= bus_req.wdata[CTL1_TRG_EN];
        internal_clock_extra_bit_q <= bus_req.wdata[CTL1_ICKS];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_q   <= 1'b0;
      irq_q   <= 1'b0;
      rdata_q <= 8'h00;
      vec_q   <= 16'h0000;
    end else if (standby_hold) begin
      out_q   <= 1'b0;
      irq_q   <= 1'b0;
      rdata_q <= 8'h00;
      vec_q   <= SHARED_VEC;
    end else begin
      out_q   <= out_d;
      irq_q   <= |(flags_d & irq_en);
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
      vec_q   <= SHARED_VEC;
    end
  end

  assign rd_data          = rdata_q;
  assign waveform_out_pin = out_q;
  assign timer_irq        = irq_q;
  assign irq_vector       = vec_q;

endmodule : ebt_timer

// ===== core/ebt_pkg.sv
// Constants, register map and carrier types of the 8-bit compare timer.
// Assumes one system clock and a plain register port with 3-bit index.
//
// Overview of operation
// - Each match holds, clears, sets or toggles output
// - Counter clears on match A or match B
// - External reset pin rising edge clears counter
// - Low-power modes hold all registers but the interrupt vector in reset
// - Three flagged sources share one interrupt vector
// - Each interrupt source has its own enable
// - Clear on A, select 0110 gives PWM
// - Clear on B, falling trigger gives one-shot
// - Clear beats a simultaneous counter write
// - Counter write beats a simultaneous increment
// - Compare write suppresses its simultaneous match
// - Toggle beats high beats low beats hold
// - Internal clock counts on divided clock falling edge
// - Clock switch high to low counts once
// - Internal/external source switch may count once
// - Match flags set when counter leaves match value
// - Trigger enable halts until selected trigger edge
// - Edge field: none, rising, falling, both
// - Output stays low until first match
package ebt_pkg;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_COUNT = 3'h0;
  localparam logic [2:0] ADDR_CMP_A = 3'h1;
  localparam logic [2:0] ADDR_CMP_B = 3'h2;
  localparam logic [2:0] ADDR_CTL0  = 3'h3;
  localparam logic [2:0] ADDR_CSR   = 3'h4;
  localparam logic [2:0] ADDR_CTL1  = 3'h5;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL0_IE_A    = 7;
  localparam int CTL0_IE_B    = 6;
  localparam int CTL0_IE_OVF  = 5;
  localparam int CTL0_CLR_HI  = 4;
  localparam int CTL0_CLR_LO  = 3;
  localparam int CTL0_CKS_HI  = 2;
  localparam int CSR_FLAG_A   = 7;
  localparam int CSR_FLAG_B   = 6;
  localparam int CSR_FLAG_OVF = 5;
  localparam int CTL1_EDGE_HI = 4;
  localparam int CTL1_EDGE_LO = 3;
  localparam int CTL1_TRG_EN  = 2;
  localparam int CTL1_ICKS    = 0;

  // ---------------------------------------------------------------
  // Reset values and fixed read bits
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_COUNT   = 8'h00;
  localparam logic [7:0]  RST_CMP     = 8'hFF;
  localparam logic [7:0]  RST_CTL0    = 8'h00;
  localparam logic [3:0]  RST_OS      = 4'h0;
  localparam logic [7:0]  CSR_ONES    = 8'h10;
  localparam logic [7:0]  CTL1_ONES   = 8'hE2;
  localparam logic [7:0]  COUNT_TOP   = 8'hFF;
  localparam logic [15:0] SHARED_VEC  = 16'h0022;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CLR_NONE  = 2'h0;
  localparam logic [1:0] CLR_A     = 2'h1;
  localparam logic [1:0] CLR_B     = 2'h2;
  localparam logic [1:0] CLR_PIN   = 2'h3;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] ACT_HOLD  = 2'h0;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_HIGH  = 2'h2;
  localparam logic [1:0] ACT_TOG   = 2'h3;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
  localparam int PRESC_W   = 7;
  localparam int PIN_COUNT = 2;
  localparam int PIN_TRG   = 0;
  localparam int PIN_CLR   = 1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HALT  = 2'b01,
    ST_COUNT = 2'b10
  } ebt_run_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ebt_bus_req_t;

  typedef struct packed {
    logic trigger_input_pin;
    logic counter_reset_input_pin;
    logic ext_clock_pin;
  } ebt_pins_t;

endpackage : ebt_pkg

// ===== core/ebt_edge.sv
// Edge detector for one synchronous pin.
// Assumes the pin is already synchronous to ref_clk.
`timescale 1ns/10ps
module ebt_edge (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic hold,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  import ebt_pkg::*;

  logic prev_q;

  assign rise = pin & ~prev_q;
  assign fall = ~pin & prev_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else if (hold) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin;
    end
  end

endmodule : ebt_edge

// ===== testbench/ebt_timer_asserts.sv
// Port-level assertions of the compare timer.
// Assumes binding onto ebt_timer; shadows follow bus writes and clear in standby_hold.
`timescale 1ns/10ps
module ebt_timer_asserts import ebt_pkg::*; (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire ebt_pkg::ebt_bus_req_t bus_req,
  input wire logic [7:0]            rd_data,
  input wire ebt_pkg::ebt_pins_t    pins,
  input wire logic                  standby_hold,
  input wire logic                  waveform_out_pin,
  input wire logic                  timer_irq,
  input wire logic [15:0]           irq_vector
);
  // ---
  // Shadows of enables and output select
  // ---
  logic [2:0] ie_q;
  logic [3:0] os_q;
  logic       rise_q;
  wire        wr_ctl0 = bus_req.wr && bus_req.addr == ADDR_CTL0;
  wire        wr_csr  = bus_req.wr && bus_req.addr == ADDR_CSR;
  wire        up_os   = wr_csr && (bus_req.wdata[3] || bus_req.wdata[1]);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ie_q   <= 3'h0;
      os_q   <= 4'h0;
      rise_q <= 1'b0;
    end else begin
      ie_q   <= standby_hold ? 3'h0 : wr_ctl0 ? bus_req.wdata[7:5] : ie_q;
      os_q   <= standby_hold ? 4'h0 : wr_csr ? bus_req.wdata[3:0] : os_q;
      rise_q <= !standby_hold && (rise_q || up_os);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rd_csr;  bus_req.rd && bus_req.addr == ADDR_CSR;  endsequence
  sequence s_rd_ctl1; bus_req.rd && bus_req.addr == ADDR_CTL1; endsequence
  sequence s_release; standby_hold ##1 !standby_hold;          endsequence

  AST_VECTOR: assert property (1'b1 |=> irq_vector == SHARED_VEC)
    else $error("shared vector wrong");
  AST_STBY_LOW: assert property (standby_hold |=> !waveform_out_pin && !timer_irq)
    else $error("low-power mode left output or request set");
  AST_STBY_CSR: assert property (s_release ##0 s_rd_csr |=> rd_data == CSR_ONES)
    else $error("status not at reset value after low-power mode");
  AST_STBY_CTL1: assert property (s_release ##0 s_rd_ctl1 |=> rd_data == CTL1_ONES)
    else $error("control one not at reset value after low-power mode");
  AST_IRQ_GATED: assert property (ie_q == 3'h0 && $past(ie_q) == 3'h0 |-> !timer_irq)
    else $error("request with all enables clear");
  AST_IRQ_FLAG: assert property ((timer_irq && !standby_hold) ##0 s_rd_csr
    |=> rd_data[7:5] != 3'h0)
    else $error("request without a flag");
  AST_OUT_HOLD: assert property (os_q == 4'h0 && $past(os_q) == 4'h0 && !$past(standby_hold)
    |-> $stable(waveform_out_pin))
    else $error("output moved with no-change selected");
  AST_OUT_LOW: assert property (!rise_q |-> !waveform_out_pin)
    else $error("output high with no rising action selected");
endmodule : ebt_timer_asserts

bind ebt_timer ebt_timer_asserts i_ebt_timer_asserts (.ref_clk, .rst, .bus_req, .rd_data,
  .pins, .standby_hold, .waveform_out_pin, .timer_irq, .irq_vector);

// ===== testbench/ebt_pin_src.sv
// Far-side source of trigger, counter clear and external clock pins.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/10ps
module ebt_pin_src (
  input  wire logic          ref_clk,
  output ebt_pkg::ebt_pins_t pins
);
  import ebt_pkg::*;
  initial pins = '0;

  // ---
  // Pulses held two clocks, then four low
  // ---
  task automatic ext_pulse();
    pins.ext_clock_pin <= 1'b1;
    repeat (2) @(posedge ref_clk);
    pins.ext_clock_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : ext_pulse

  task automatic clr_pulse();
    pins.counter_reset_input_pin <= 1'b1;
    repeat (2) @(posedge ref_clk);
    pins.counter_reset_input_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : clr_pulse

  task automatic set_trg(input logic v);
    pins.trigger_input_pin <= v;
    repeat (4) @(posedge ref_clk);
  endtask : set_trg
endmodule : ebt_pin_src

// ===== testbench/ebt_timer_test.sv
// Self-checking bench of the compare timer.
// Assumes ebt_pin_src drives the pins; external clock paces the counter.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, g, e); end end
module ebt_timer_test;
  import ebt_pkg::*;
  logic         ref_clk;
  logic         rst;
  logic         standby_hold;
  ebt_bus_req_t bus_req;
  ebt_pins_t    pins;
  logic [7:0]   rd_data;
  logic         waveform_out_pin;
  logic         timer_irq;
  logic [15:0]  irq_vector;
  logic [7:0]   rv;
  logic [7:0]   exp_cnt;
  logic         exp_out;
  logic [7:0]   cmp_a;
  logic [7:0]   cmp_b;
  logic [1:0]   clr_sel;
  logic [3:0]   os;
  int           n_mismatch;
  int           checks_done;

  ebt_timer i_ebt_timer (.ref_clk, .rst, .bus_req, .rd_data, .pins, .standby_hold,
    .waveform_out_pin, .timer_irq, .irq_vector);
  ebt_pin_src i_ebt_pin_src (.ref_clk, .pins);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ---
  // Bus, reference model and closing
  // ---
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
  endtask : wr

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    rv = rd_data;
    `CHK(rv, e)
    @(posedge ref_clk);
  endtask : chk_rd

  task automatic tick();
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] m;
    i_ebt_pin_src.ext_pulse();
    a = (exp_cnt == cmp_a) ? os[1:0] : ACT_HOLD;
    b = (exp_cnt == cmp_b) ? os[3:2] : ACT_HOLD;
    m = (a > b) ? a : b;
    exp_out = (m == ACT_TOG) ? ~exp_out : (m == ACT_HIGH) ? 1'b1
            : (m == ACT_LOW) ? 1'b0 : exp_out;
    if ((exp_cnt == cmp_a && clr_sel == CLR_A) || (exp_cnt == cmp_b && clr_sel == CLR_B))
      exp_cnt = 8'h00;
    else
      exp_cnt = exp_cnt + 8'h01;
    `CHK(waveform_out_pin, exp_out)
  endtask : tick

  task automatic cfg(input logic [1:0] c, input logic [7:0] a, input logic [7:0] b,
                     input logic [3:0] o);
    standby_hold <= 1'b1;
    @(posedge ref_clk);
    standby_hold <= 1'b0;
    @(posedge ref_clk);
    {clr_sel, cmp_a, cmp_b, os, exp_cnt, exp_out} = {c, a, b, o, 8'h00, 1'b0};
    `CHK(waveform_out_pin, 1'b0)
    wr(ADDR_CMP_A, a);
    wr(ADDR_CMP_B, b);
    wr(ADDR_CSR, {4'h0, o});
    wr(ADDR_CTL0, {3'b000, c, CKS_EXT_RISE});
  endtask : cfg

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ---
  // Scenarios
  // ---
  task automatic t_reset();
    logic [2:0] ix [7] = '{ADDR_COUNT, ADDR_CMP_A, ADDR_CMP_B, ADDR_CTL0, ADDR_CSR,
                           ADDR_CTL1, 3'h6};
    logic [7:0] vx [7] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h10, 8'hE2, 8'h00};
    for (int i = 0; i < 7; i++)
      chk_rd(ix[i], vx[i]);
    wr(ADDR_CTL1, 8'h00);
    chk_rd(ADDR_CTL1, 8'hE2);
    `CHK(irq_vector, 16'h0022)
  endtask : t_reset

  task automatic t_actions();
    for (int i = 0; i < 16; i++) begin
      cfg(CLR_A, 8'h01, 8'h01, i[3:0]);
      repeat (4) tick();
    end
  endtask : t_actions

  task automatic t_pwm();
    cfg(CLR_A, 8'h03, 8'h01, 4'b0110);
    repeat (8) tick();
    chk_rd(ADDR_COUNT, exp_cnt);
    cfg(CLR_B, 8'h01, 8'h03, 4'b0110);
    repeat (9) tick();
    chk_rd(ADDR_COUNT, exp_cnt);
  endtask : t_pwm

  task automatic t_flags();
    cfg(CLR_NONE, 8'h02, 8'hFF, 4'h0);
    repeat (2) tick();
    chk_rd(ADDR_CSR, 8'h10);
    tick();
    chk_rd(ADDR_CSR, 8'h90);
    wr(ADDR_CTL0, 8'h85);
    repeat (2) @(posedge ref_clk);
    `CHK(timer_irq, 1'b1)
    wr(ADDR_CTL0, 8'h45);
    repeat (2) @(posedge ref_clk);
    `CHK(timer_irq, 1'b0)
    wr(ADDR_CSR, 8'h00);
    chk_rd(ADDR_CSR, 8'h10);
    wr(ADDR_COUNT, 8'hFF);
    exp_cnt = 8'hFF;
    tick();
    chk_rd(ADDR_CSR, 8'h70);
    wr(ADDR_CTL0, 8'h25);
    repeat (2) @(posedge ref_clk);
    `CHK(timer_irq, 1'b1)
    chk_rd(ADDR_CSR, 8'h70);
    wr(ADDR_CTL1, 8'h1D);
    chk_rd(ADDR_CTL1, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      standby_hold <= 1'b1;
      @(posedge ref_clk);
      standby_hold <= 1'b0;
      chk_rd(i ? ADDR_CTL1 : ADDR_CSR, i ? 8'hE2 : 8'h10);
    end
    `CHK(timer_irq, 1'b0)
  endtask : t_flags

  // Bus write and pin event land on the same clock edge
  task automatic t_contend();
    cfg(CLR_PIN, 8'h00, 8'hFF, 4'h0);
    fork
      i_ebt_pin_src.ext_pulse();
      wr(ADDR_CMP_A, 8'h00);
    join
    chk_rd(ADDR_CSR, 8'h10);
    fork
      i_ebt_pin_src.ext_pulse();
      wr(ADDR_COUNT, 8'h40);
    join
    chk_rd(ADDR_COUNT, 8'h40);
    fork
      i_ebt_pin_src.clr_pulse();
      wr(ADDR_COUNT, 8'h55);
    join
    chk_rd(ADDR_COUNT, 8'h00);
  endtask : t_contend

  task automatic t_trigger();
    logic [7:0] run;
    cfg(CLR_NONE, 8'hFF, 8'hFF, 4'h0);
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_CTL1, {3'b000, e[1:0], 3'b100});
      wr(ADDR_COUNT, 8'h00);
      i_ebt_pin_src.ext_pulse();
      chk_rd(ADDR_COUNT, 8'h00);
      run = {7'h00, e[0]};
      i_ebt_pin_src.set_trg(1'b1);
      i_ebt_pin_src.ext_pulse();
      chk_rd(ADDR_COUNT, run);
      i_ebt_pin_src.set_trg(1'b0);
      i_ebt_pin_src.ext_pulse();
      chk_rd(ADDR_COUNT, run + {7'h00, e[0] | e[1]});
    end
    wr(ADDR_CTL1, 8'h00);
  endtask : t_trigger

  task automatic t_pin_clear();
    cfg(CLR_A, 8'hFF, 8'hFF, 4'h0);
    repeat (3) i_ebt_pin_src.ext_pulse();
    i_ebt_pin_src.clr_pulse();
    chk_rd(ADDR_COUNT, 8'h03);
    wr(ADDR_CTL0, {3'b000, CLR_PIN, CKS_EXT_RISE});
    i_ebt_pin_src.clr_pulse();
    chk_rd(ADDR_COUNT, 8'h00);
  endtask : t_pin_clear

  initial begin
    rst = 1'b1;
    standby_hold = 1'b0;
    bus_req = '0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_actions();
    t_pwm();
    t_flags();
    t_trigger();
    t_pin_clear();
    t_contend();
    end_sim();
  end

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule : ebt_timer_test
